// ### hdl/dcs_pins.sv
// module: pin-level control and status logic of the quad dpll device
`timescale 1ns/10ps
module dcs_pins
  import dcs_pkg::*;
#(
  parameter int unsigned STEP_W = DCS_STEP_W
) (
  input  wire logic                              clk,
  input  wire logic                              sys_rst,
  input  wire logic                              reset_n,
  input  wire logic                              iface_sel,
  input  wire logic                              sclk,
  input  wire logic                              sda_i,
  output logic                                   sda_o,
  output logic                                   sda_oe_n,
  input  wire logic                              addr0_or_chip_select_n,
  input  wire logic                              addr1_or_data_out_i,
  output logic                                   addr1_or_data_out_o,
  output logic                                   addr1_or_data_out_oe_n,
  input  wire logic                              spi_four_wire,
  input  wire logic                              core_tx_en,
  input  wire logic                              core_tx_data,
  output logic                                   host_is_i2c,
  output logic                                   host_is_spi4,
  output logic                                   host_sdi,
  output logic                                   host_sclk_rise,
  output logic                                   host_cs_active,
  output logic [1:0]                             host_i2c_addr,
  input  wire logic                              out_enable_a_n,
  input  wire logic                              out_enable_b_n,
  input  wire logic                              oe_a_subset_en,
  input  wire logic [DCS_NUM_OUTS-1:0]           oe_a_mask,
  input  wire logic [DCS_NUM_OUTS-1:0]           oe_b_mask,
  output logic [DCS_NUM_OUTS-1:0]                out_clk_en,
  input  wire logic [DCS_NUM_LOOPS-1:0]          loop_locked,
  output logic                                   lock_lost_0_n,
  output logic                                   lock_lost_1_n,
  output logic                                   lock_lost_2_n,
  output logic                                   lock_lost_3_n,
  input  wire logic                              xtal_loss_det,
  output logic                                   xtal_signal_lost_n,
  input  wire logic [DCS_NUM_EVT-1:0]            irq_ack,
  output logic                                   irq_n,
  output logic [DCS_NUM_EVT-1:0]                 irq_pending,
  input  wire logic                              loop_select_0,
  input  wire logic                              loop_select_1,
  input  wire logic                              freq_step_up,
  input  wire logic                              freq_step_down,
  input  wire logic [STEP_W-1:0]                 step_size,
  input  wire logic [DCS_NUM_LOOPS-1:0]          controlled_osc_mode,
  output logic [DCS_NUM_LOOPS-1:0]               step_up_pulse,
  output logic [DCS_NUM_LOOPS-1:0]               step_down_pulse,
  output logic [DCS_NUM_LOOPS-1:0][STEP_W-1:0]   freq_offset_ppt
);

  dcs_state_t q;
  dcs_state_t d;
  logic [DCS_NUM_PINS-1:0] pins;
  logic [1:0]              sel;
  logic                    up_edge;
  logic                    dn_edge;
  logic [DCS_NUM_OUTS-1:0] a_gov;
  logic [DCS_NUM_OUTS-1:0] b_gov;
  logic [DCS_NUM_EVT-1:0]  evt;

  // --------------------------------------------------------------------
  // default state, loaded by the reset pin only; the async reset sets its own values
  // --------------------------------------------------------------------
  function automatic dcs_state_t dcs_defaults(input dcs_state_t s);
    dcs_state_t r;
    r          = '0;
    r.sync1    = s.sync1;
    r.sync2    = s.sync2;
    r.mode     = DCS_MODE_I2C;
    r.sda_oe_n = 1'h1;
    r.a1_oe_n  = 1'h1;
    r.clk_en   = DCS_CLK_EN_RST;
    r.lol_n    = DCS_LOL_N_RST;
    r.los_n    = DCS_LOS_N_RST;
    r.irq_n    = DCS_IRQ_N_RST;
    r.offs     = {DCS_NUM_LOOPS{DCS_OFFS_RST}};
    // edge history at the synchronised pin level so release makes no false step
    r.up_prev  = s.sync2[DCS_PIN_UP];
    r.dn_prev  = s.sync2[DCS_PIN_DN];
    r.sclk_prev = s.sync2[DCS_PIN_SCLK];
    return r;
  endfunction

  assign pins[DCS_PIN_RSTN] = reset_n;
  assign pins[DCS_PIN_SEL]  = iface_sel;
  assign pins[DCS_PIN_SCLK] = sclk;
  assign pins[DCS_PIN_SDA]  = sda_i;
  assign pins[DCS_PIN_CSN]  = addr0_or_chip_select_n;
  assign pins[DCS_PIN_A1]   = addr1_or_data_out_i;
  assign pins[DCS_PIN_OEA]  = out_enable_a_n;
  assign pins[DCS_PIN_OEB]  = out_enable_b_n;
  assign pins[DCS_PIN_LS0]  = loop_select_0;
  assign pins[DCS_PIN_LS1]  = loop_select_1;
  assign pins[DCS_PIN_UP]   = freq_step_up;
  assign pins[DCS_PIN_DN]   = freq_step_down;

  always_comb begin
    d       = q;
    d.sync1 = pins;
    d.sync2 = q.sync1;

    // ------------------------------------------------------------------
    // host interface mode and pin sharing
    // ------------------------------------------------------------------
    if (q.sync2[DCS_PIN_SEL]) begin
      d.mode = DCS_MODE_I2C;
    end else if (spi_four_wire) begin
      d.mode = DCS_MODE_SPI4;
    end else begin
      d.mode = DCS_MODE_SPI3;
    end
    d.sclk_prev = q.sync2[DCS_PIN_SCLK];
    d.sclk_rise = q.sync2[DCS_PIN_SCLK] & ~q.sclk_prev;
    d.sdi       = q.sync2[DCS_PIN_SDA];
    d.cs_act    = 1'h0;
    d.i2c_addr  = 2'h0;
    d.sda_o     = 1'h0;
    d.sda_oe_n  = 1'h1;
    d.a1_o      = 1'h0;
    d.a1_oe_n   = 1'h1;
    case (q.mode)
      DCS_MODE_I2C: begin
        // open drain: only ever pull the line low
        d.sda_oe_n = ~(core_tx_en & ~core_tx_data);
        d.i2c_addr = {q.sync2[DCS_PIN_A1], q.sync2[DCS_PIN_CSN]};
      end
      DCS_MODE_SPI3: begin
        d.cs_act   = ~q.sync2[DCS_PIN_CSN];
        d.sda_o    = core_tx_data;
        d.sda_oe_n = ~(core_tx_en & ~q.sync2[DCS_PIN_CSN]);
      end
      DCS_MODE_SPI4: begin
        d.cs_act  = ~q.sync2[DCS_PIN_CSN];
        // push-pull output while selected; data pin stays input
        d.a1_o    = core_tx_data;
        d.a1_oe_n = q.sync2[DCS_PIN_CSN];
      end
      default: begin
        d.mode = DCS_MODE_I2C;
      end
    endcase

    // ------------------------------------------------------------------
    // output enables
    // ------------------------------------------------------------------
    a_gov    = oe_a_subset_en ? oe_a_mask : {DCS_NUM_OUTS{1'h1}};
    b_gov    = oe_b_mask;
    d.clk_en = ~((a_gov & {DCS_NUM_OUTS{q.sync2[DCS_PIN_OEA]}}) |
                 (b_gov & {DCS_NUM_OUTS{q.sync2[DCS_PIN_OEB]}}));

    // ------------------------------------------------------------------
    // status pins and interrupt
    // ------------------------------------------------------------------
    d.lol_n = loop_locked;
    d.los_n = ~xtal_loss_det;
    evt     = {d.los_n ^ q.los_n, d.lol_n ^ q.lol_n};
    // a new event wins over an acknowledge in the same cycle
    d.pend  = (q.pend & ~irq_ack) | evt;
    d.irq_n = ~|d.pend;

    // ------------------------------------------------------------------
    // frequency stepping
    // ------------------------------------------------------------------
    sel       = {q.sync2[DCS_PIN_LS1], q.sync2[DCS_PIN_LS0]};
    up_edge   = q.sync2[DCS_PIN_UP] & ~q.up_prev;
    dn_edge   = q.sync2[DCS_PIN_DN] & ~q.dn_prev;
    d.up_prev = q.sync2[DCS_PIN_UP];
    d.dn_prev = q.sync2[DCS_PIN_DN];
    d.up_pulse = '0;
    d.dn_pulse = '0;
    // coincident up and down edges cancel rather than pick a winner
    if (up_edge & ~dn_edge) begin
      d.up_pulse[sel] = 1'h1;
      d.offs[sel] = DCS_STEP_W'(q.offs[sel] + step_size);
    end else if (dn_edge & ~up_edge) begin
      d.dn_pulse[sel] = 1'h1;
      d.offs[sel] = DCS_STEP_W'(q.offs[sel] - step_size);
    end

    if (!q.sync2[DCS_PIN_RSTN]) begin
      d = dcs_defaults(d);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q           <= '0;
      q.sync1     <= DCS_PIN_IDLE;
      q.sync2     <= DCS_PIN_IDLE;
      q.mode      <= DCS_MODE_I2C;
      q.sda_oe_n  <= 1'h1;
      q.a1_oe_n   <= 1'h1;
      q.clk_en    <= DCS_CLK_EN_RST;
      q.lol_n     <= DCS_LOL_N_RST;
      q.los_n     <= DCS_LOS_N_RST;
      q.irq_n     <= DCS_IRQ_N_RST;
    end else begin
      q <= d;
    end
  end

  // controlled_osc_mode only tells the loop how to read the offset
  logic unused_osc;
  assign unused_osc = ^controlled_osc_mode;

  assign sda_o                  = q.sda_o;
  assign sda_oe_n               = q.sda_oe_n;
  assign addr1_or_data_out_o    = q.a1_o;
  assign addr1_or_data_out_oe_n = q.a1_oe_n;
  assign host_is_i2c            = (q.mode == DCS_MODE_I2C);
  assign host_is_spi4           = (q.mode == DCS_MODE_SPI4);
  assign host_sdi               = q.sdi;
  assign host_sclk_rise         = q.sclk_rise;
  assign host_cs_active         = q.cs_act;
  assign host_i2c_addr          = q.i2c_addr;
  assign out_clk_en             = q.clk_en;
  assign lock_lost_0_n          = q.lol_n[0];
  assign lock_lost_1_n          = q.lol_n[1];
  assign lock_lost_2_n          = q.lol_n[2];
  assign lock_lost_3_n          = q.lol_n[3];
  assign xtal_signal_lost_n     = q.los_n;
  assign irq_n                  = q.irq_n;
  assign irq_pending            = q.pend;
  assign step_up_pulse          = q.up_pulse;
  assign step_down_pulse        = q.dn_pulse;
  assign freq_offset_ppt        = q.offs;

endmodule

// ### hdl/dcs_pkg.sv
// package: constants and state types for the dpll control/status pin block
package dcs_pkg;

  localparam int unsigned DCS_NUM_LOOPS = 4;
  localparam int unsigned DCS_NUM_OUTS  = 8;
  localparam int unsigned DCS_STEP_W    = 32;
  localparam int unsigned DCS_NUM_EVT   = DCS_NUM_LOOPS + 1;

  // --------------------------------------------------------------------
  // pin input vector positions
  // --------------------------------------------------------------------
  localparam int unsigned DCS_PIN_RSTN = 0;
  localparam int unsigned DCS_PIN_SEL  = 1;
  localparam int unsigned DCS_PIN_SCLK = 2;
  localparam int unsigned DCS_PIN_SDA  = 3;
  localparam int unsigned DCS_PIN_CSN  = 4;
  localparam int unsigned DCS_PIN_A1   = 5;
  localparam int unsigned DCS_PIN_OEA  = 6;
  localparam int unsigned DCS_PIN_OEB  = 7;
  localparam int unsigned DCS_PIN_LS0  = 8;
  localparam int unsigned DCS_PIN_LS1  = 9;
  localparam int unsigned DCS_PIN_UP   = 10;
  localparam int unsigned DCS_PIN_DN   = 11;
  localparam int unsigned DCS_NUM_PINS = 12;

  // idle levels of the pins: pull-ups on reset, select and chip select
  localparam logic [DCS_NUM_PINS-1:0] DCS_PIN_IDLE = 12'h013;

  // --------------------------------------------------------------------
  // reset values
  // --------------------------------------------------------------------
  localparam logic                     DCS_IRQ_N_RST = 1'h1;
  localparam logic [DCS_NUM_LOOPS-1:0] DCS_LOL_N_RST = 4'h0;
  localparam logic                     DCS_LOS_N_RST = 1'h1;
  localparam logic [DCS_NUM_OUTS-1:0]  DCS_CLK_EN_RST = 8'h00;
  localparam logic [DCS_STEP_W-1:0]    DCS_OFFS_RST  = 32'h0000_0000;

  typedef enum logic [1:0] {
    DCS_MODE_I2C,
    DCS_MODE_SPI3,
    DCS_MODE_SPI4
  } dcs_mode_t;

  typedef struct packed {
    logic [DCS_NUM_PINS-1:0]                  sync1;
    logic [DCS_NUM_PINS-1:0]                  sync2;
    logic                                     sclk_prev;
    logic                                     up_prev;
    logic                                     dn_prev;
    dcs_mode_t                                mode;
    logic                                     sda_o;
    logic                                     sda_oe_n;
    logic                                     a1_o;
    logic                                     a1_oe_n;
    logic                                     sdi;
    logic                                     sclk_rise;
    logic                                     cs_act;
    logic [1:0]                               i2c_addr;
    logic [DCS_NUM_OUTS-1:0]                  clk_en;
    logic [DCS_NUM_LOOPS-1:0]                 lol_n;
    logic                                     los_n;
    logic [DCS_NUM_EVT-1:0]                   pend;
    logic                                     irq_n;
    logic [DCS_NUM_LOOPS-1:0]                 up_pulse;
    logic [DCS_NUM_LOOPS-1:0]                 dn_pulse;
    logic [DCS_NUM_LOOPS-1:0][DCS_STEP_W-1:0] offs;
  } dcs_state_t;

endpackage

// ### tb/dcs_host_model.sv
// partner: host serial master driving clock, select and data pins
`timescale 1ns/10ps
module dcs_host_model (
  input  wire logic go,
  output logic      sclk,
  output logic      csn,
  output logic      sda,
  output logic      sda_en
);
  initial begin
    sclk = 1'h0;
    csn = 1'h1;
    sda = 1'h0;
    sda_en = 1'h0;
  end
  // one eight-bit frame per go; the clock stands still between frames
  always @(posedge go) begin
    csn = 1'h0;
    sda_en = 1'h1;
    repeat (8) begin
      sda = ~sda;
      #200 sclk = 1'h1;
      #200 sclk = 1'h0;
    end
    #200 csn = 1'h1;
    sda_en = 1'h0;
  end
endmodule

// ### tb/dcs_pins_properties.sv
// checker: timing properties of the pin control and status block
`timescale 1ns/10ps
module dcs_pins_properties
  import dcs_pkg::*;
#(
  parameter int unsigned STEP_W = DCS_STEP_W
) (
  input wire logic                    clk,
  input wire logic                    sys_rst,
  input wire logic                    reset_n,
  input wire logic                    iface_sel,
  input wire logic                    host_is_i2c,
  input wire logic                    out_enable_a_n,
  input wire logic                    oe_a_subset_en,
  input wire logic [7:0]              oe_b_mask,
  input wire logic [7:0]              out_clk_en,
  input wire logic [3:0]              loop_locked,
  input wire logic                    lock_lost_0_n,
  input wire logic                    xtal_loss_det,
  input wire logic                    xtal_signal_lost_n,
  input wire logic [4:0]              irq_ack,
  input wire logic                    irq_n,
  input wire logic [4:0]              irq_pending,
  input wire logic [STEP_W-1:0]       step_size,
  input wire logic [3:0]              step_up_pulse,
  input wire logic [3:0]              step_down_pulse,
  input wire logic [3:0][STEP_W-1:0]  freq_offset_ppt
);
  // pin reset history: the soft reset reaches the state late, so wait it out
  logic [4:0] rst_hist_q;
  logic       run;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
      rst_hist_q <= 5'h00;
    else
      rst_hist_q <= {rst_hist_q[3:0], reset_n};
  end
  assign run = &rst_hist_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_lock; run |-> lock_lost_0_n == $past(loop_locked[0]); endproperty
  a_lock: assert property (p_lock) else $error("lock pin wrong");
  property p_los; run |-> xtal_signal_lost_n == !$past(xtal_loss_det); endproperty
  a_los: assert property (p_los) else $error("xtal alarm wrong");
  property p_irq; irq_n == !(|irq_pending); endproperty
  a_irq: assert property (p_irq) else $error("irq level wrong");
  property p_ack; run && irq_pending[0] && irq_ack[0]
    && loop_locked[0] == lock_lost_0_n |=> !irq_pending[0]; endproperty
  a_ack: assert property (p_ack) else $error("ack ignored");
  property p_mode; run && $past(iface_sel, 2) == $past(iface_sel, 3)
    && $past(iface_sel, 3) == $past(iface_sel, 4)
    |-> host_is_i2c == $past(iface_sel, 3); endproperty
  a_mode: assert property (p_mode) else $error("mode wrong");
  property p_oe; run && $past(out_enable_a_n, 2) && $past(out_enable_a_n, 3)
    && !oe_a_subset_en && !$past(oe_a_subset_en) |-> out_clk_en == 8'h00;
  endproperty
  a_oe: assert property (p_oe) else $error("outputs not disabled");
  property p_oeb; run && !$past(out_enable_a_n, 2) && !$past(out_enable_a_n, 3)
    && oe_b_mask == 8'h00 && $past(oe_b_mask) == 8'h00 |-> out_clk_en == 8'hFF;
  endproperty
  a_oeb: assert property (p_oeb) else $error("outputs not enabled");
  property p_up; step_up_pulse[0] |->
    freq_offset_ppt[0] == $past(freq_offset_ppt[0]) + $past(step_size);
  endproperty
  a_up: assert property (p_up) else $error("up step wrong");
  property p_dn; step_down_pulse[3] |->
    freq_offset_ppt[3] == $past(freq_offset_ppt[3]) - $past(step_size);
  endproperty
  a_dn: assert property (p_dn) else $error("down step wrong");
  property p_hot; $onehot0({step_up_pulse, step_down_pulse}); endproperty
  a_hot: assert property (p_hot) else $error("several steps");
endmodule
bind dcs_pins dcs_pins_properties #(.STEP_W(STEP_W)) i_props (.*);

// ### tb/dcs_pins_tb.sv
// testbench: random and corner stimulus of the pin control/status block
`timescale 1ns/10ps
module dcs_pins_tb;
  logic clk = 1'h0, sys_rst = 1'h1, reset_n = 1'h1, iface_sel = 1'h1;
  logic sclk, addr0_or_chip_select_n, h_sda, h_en, go = 1'h0, a1_s = 1'h0;
  logic spi_four_wire = 1'h0, core_tx_en = 1'h0, core_tx_data = 1'h0;
  // enable b is always driven to a defined level by the bench
  logic out_enable_a_n = 1'h0, out_enable_b_n = 1'h0, oe_a_subset_en = 1'h0;
  logic [7:0] oe_a_mask = 8'h00, oe_b_mask = 8'h00, out_clk_en;
  logic [3:0] loop_locked = 4'h0, controlled_osc_mode = 4'h0;
  logic [3:0] step_up_pulse, step_down_pulse;
  logic xtal_loss_det = 1'h0, loop_select_0 = 1'h0, loop_select_1 = 1'h0;
  logic freq_step_up = 1'h0, freq_step_down = 1'h0;
  logic [4:0] irq_ack = 5'h00, irq_pending, prev_st = 5'h00;
  logic [31:0] step_size = 32'h0000_0001;
  logic [3:0][31:0] freq_offset_ppt;
  logic [31:0] exp_offs [4] = '{default: 32'h0000_0000};
  logic sda_o, sda_oe_n, addr1_or_data_out_o, addr1_or_data_out_oe_n;
  logic host_is_i2c, host_is_spi4, host_sdi, host_sclk_rise, host_cs_active;
  logic [1:0] host_i2c_addr;
  logic lock_lost_0_n, lock_lost_1_n, lock_lost_2_n, lock_lost_3_n;
  logic xtal_signal_lost_n, irq_n;
  // released data line floats to its pull-up
  wire sda_i = !sda_oe_n ? sda_o : (h_en ? h_sda : 1'h1);
  wire addr1_or_data_out_i = !addr1_or_data_out_oe_n ? addr1_or_data_out_o : a1_s;
  int seed = 32'h1E0EB4B0, errors = 0, samples_checked = 0, rises = 0;

  dcs_pins i_dut (.*);
  dcs_host_model i_host (.go(go), .sclk(sclk), .csn(addr0_or_chip_select_n),
                         .sda(h_sda), .sda_en(h_en));

  always #25 clk = ~clk;
  always @(posedge clk) if (host_sclk_rise === 1'h1) rises++;

  task automatic chk(input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: expected %h got %h", $time, exp, got);
    end
  endtask
  task automatic finish_test;
    $display("errors %0d checks %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  function automatic logic [7:0] exp_en();
    return ~(({8{out_enable_a_n}} & (oe_a_subset_en ? oe_a_mask : 8'hFF))
             | ({8{out_enable_b_n}} & oe_b_mask));
  endfunction
  task automatic step(input logic [1:0] s, input logic u, input logic d);
    {loop_select_1, loop_select_0} = s;
    step_size = $random(seed);
    cyc(3);
    {freq_step_up, freq_step_down} = {u, d};
    cyc(4);
    if (u && !d) exp_offs[s] += step_size;
    if (d && !u) exp_offs[s] -= step_size;
    {freq_step_up, freq_step_down} = 2'h0;
    cyc(4);
    for (int k = 0; k < 4; k++) chk(exp_offs[k], freq_offset_ppt[k]);
  endtask

  initial begin
    #250000;
    errors++;
    finish_test();
  end

  initial begin
    cyc(20);
    sys_rst = 1'h0;
    cyc(3);
    repeat (24) begin
      {xtal_loss_det, loop_locked} = $random(seed);
      irq_ack = $random(seed);
      cyc(1);
      chk(loop_locked, {lock_lost_3_n, lock_lost_2_n, lock_lost_1_n,
                        lock_lost_0_n});
      chk(!xtal_loss_det, xtal_signal_lost_n);
      chk({xtal_loss_det, loop_locked} ^ prev_st, irq_pending);
      prev_st = {xtal_loss_det, loop_locked};
      irq_ack = 5'h1F;
      cyc(1);
      irq_ack = 5'h00;
      chk(1'h1, irq_n);
    end
    for (int k = 0; k < 8; k++) step(k[1:0], !k[2], k[2]);
    step(2'h1, 1'h1, 1'h1);
    for (int k = 0; k < 16; k++) begin
      {out_enable_a_n, out_enable_b_n, oe_a_subset_en} = $random(seed);
      {oe_a_mask, oe_b_mask} = $random(seed);
      if (k == 0) {out_enable_a_n, oe_b_mask} = 9'h000;
      cyc(4);
      chk(exp_en(), out_clk_en);
    end
    for (int m = 0; m < 3; m++) begin
      {iface_sel, spi_four_wire, a1_s} = {m == 0, m == 2, m[0]};
      {core_tx_en, core_tx_data} = {1'h1, 1'($random(seed))};
      cyc(5);
      chk(m == 0, host_is_i2c);
      chk(m == 2, host_is_spi4);
      if (m == 0) chk({a1_s, 1'h1}, host_i2c_addr);
      rises = 0;
      go = 1'h1;
      cyc(30);
      go = 1'h0;
      chk(m != 0, host_cs_active);
      chk(m == 0 ? core_tx_data : m == 2, sda_oe_n);
      chk(m != 2, addr1_or_data_out_oe_n);
      if (m == 1) chk(core_tx_data, sda_o);
      cyc(50);
      chk(32'h8, rises);
      chk(m != 0 || core_tx_data, host_sdi);
    end
    reset_n = 1'h0;
    cyc(5);
    chk(32'h0, freq_offset_ppt[3]);
    chk({1'h1, 8'h00}, {irq_n, out_clk_en});
    reset_n = 1'h1;
    cyc(6);
    chk(32'h0, freq_offset_ppt[0]);
    finish_test();
  end
endmodule
